// *** fss_pkg.sv ***
// Shared types, object codes, process data layout and reset values for the fieldbus slave.
package fss_pkg;

  typedef enum logic [3:0] {
    FSS_INIT   = 4'h1,
    FSS_PREOP  = 4'h2,
    FSS_SAFEOP = 4'h4,
    FSS_OP     = 4'h8
  } fss_state_e;

  // Control-mode parameter: only this value hands the drive to the fieldbus.
  localparam logic [7:0]  CTRL_MODE_BUS = 8'h09;
  localparam logic [31:0] CTRL_MODE_RST = 32'h0000_0009;

  // Drive-profile operation mode codes.
  localparam logic [7:0] MODE_PP  = 8'h01;
  localparam logic [7:0] MODE_PV  = 8'h03;
  localparam logic [7:0] MODE_PT  = 8'h04;
  localparam logic [7:0] MODE_HM  = 8'h06;
  localparam logic [7:0] MODE_CSP = 8'h08;
  localparam logic [7:0] MODE_CSV = 8'h09;
  localparam logic [7:0] MODE_CST = 8'h0a;

  // Object dictionary: index and storage slot of each object, subindex of the control mode only.
  localparam int unsigned OD_SLOTS = 8;
  localparam int unsigned SLOT_W   = 3;
  localparam logic [15:0] OD_IDX_CTRL_MODE  = 16'h2002;
  localparam logic [7:0]  OD_SUB_CTRL_MODE  = 8'h01;
  localparam logic [15:0] OD_IDX_CTRL_WORD  = 16'h6040;
  localparam logic [15:0] OD_IDX_MODE_OP    = 16'h6060;
  localparam logic [15:0] OD_IDX_TARGET_POS = 16'h607a;
  localparam logic [15:0] OD_IDX_PROBE_FN   = 16'h60b8;
  localparam logic [15:0] OD_IDX_ERR_CODE   = 16'h603f;
  localparam logic [15:0] OD_IDX_STATUS     = 16'h6041;
  localparam logic [15:0] OD_IDX_POS_ACT    = 16'h6064;
  localparam logic [SLOT_W-1:0] SLOT_CTRL_MODE  = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_CTRL_WORD  = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_MODE_OP    = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_TARGET_POS = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_PROBE_FN   = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_ERR_CODE   = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_STATUS     = 3'h6;
  localparam logic [SLOT_W-1:0] SLOT_POS_ACT    = 3'h7;
  localparam logic [31:0] OD_RST_VAL = 32'h0000_0000;

  // Receive image: control word, target position, touch probe function.
  localparam int unsigned PDO_W      = 64;
  localparam int unsigned RX_CW_LSB  = 0;
  localparam int unsigned RX_POS_LSB = 16;
  localparam int unsigned RX_PF_LSB  = 48;
  // Transmit image: status word, actual position, error code.
  localparam int unsigned TX_SW_LSB  = 0;
  localparam int unsigned TX_POS_LSB = 16;
  localparam int unsigned TX_EC_LSB  = 48;

  function automatic logic [1:0] fss_level(input fss_state_e s);
    case (s)
      FSS_PREOP:  fss_level = 2'd1;
      FSS_SAFEOP: fss_level = 2'd2;
      FSS_OP:     fss_level = 2'd3;
      default:    fss_level = 2'd0;
    endcase
  endfunction

endpackage

// *** fss_od_store.sv ***
// Object dictionary storage with a mailbox port and a cyclic command port.
`timescale 1ns/1ps
module fss_od_store (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      sdo_wr_i,
  input  wire logic [fss_pkg::SLOT_W-1:0] sdo_slot_i,
  input  wire logic [31:0]               sdo_wdata_i,
  input  wire logic                      pdo_wr_i,
  input  wire logic [15:0]               pdo_ctrl_word_i,
  input  wire logic [31:0]               pdo_target_pos_i,
  input  wire logic [15:0]               pdo_probe_fn_i,
  output logic      [31:0]               rd_data_o,
  output logic      [7:0]                ctrl_mode_o,
  output logic      [7:0]                mode_op_o,
  output logic      [15:0]               ctrl_word_o,
  output logic      [31:0]               target_pos_o,
  output logic      [15:0]               probe_fn_o
);
  import fss_pkg::*;

  logic [31:0] slot_r [OD_SLOTS];

  // The cyclic port wins a clash on a shared slot, since its value is the newer command.
  for (genvar g = 0; g < OD_SLOTS; g++) begin : g_slot
    localparam logic [SLOT_W-1:0] SLOT = SLOT_W'(g);
    localparam logic [31:0] RST = (SLOT == SLOT_CTRL_MODE) ? CTRL_MODE_RST : OD_RST_VAL;
    logic        pdo_hit;
    logic [31:0] pdo_val;
    assign pdo_hit = pdo_wr_i && (SLOT == SLOT_CTRL_WORD || SLOT == SLOT_TARGET_POS ||
                                  SLOT == SLOT_PROBE_FN);
    assign pdo_val = (SLOT == SLOT_CTRL_WORD) ? {16'h0000, pdo_ctrl_word_i} :
                     (SLOT == SLOT_PROBE_FN)  ? {16'h0000, pdo_probe_fn_i} : pdo_target_pos_i;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        slot_r[g] <= RST;
      end else if (pdo_hit) begin
        slot_r[g] <= pdo_val;
      end else if (sdo_wr_i && sdo_slot_i == SLOT) begin
        slot_r[g] <= sdo_wdata_i;
      end
    end
  end

  assign rd_data_o    = slot_r[sdo_slot_i];
  assign ctrl_mode_o  = slot_r[SLOT_CTRL_MODE][7:0];
  assign mode_op_o    = slot_r[SLOT_MODE_OP][7:0];
  assign ctrl_word_o  = slot_r[SLOT_CTRL_WORD][15:0];
  assign target_pos_o = slot_r[SLOT_TARGET_POS];
  assign probe_fn_o   = slot_r[SLOT_PROBE_FN][15:0];

endmodule // fss_od_store

// *** fss_slave.sv ***
// Fieldbus slave communication state machine with mailbox and cyclic process data.
//
// Behaviour
// - Four communication states: Init, Pre-Operational, Safe-Operational, Operational.
// - Upward moves go one state at a time, in order.
// - Any request to a lower state is taken at once.
// - Init offers no mailbox or process data traffic.
// - Pre-Operational serves mailbox traffic for mapping setup.
// - Safe-Operational sends inputs and mailbox but discards received outputs.
// - Operational applies outputs, sends inputs and keeps the mailbox.
// - Commands come in receive images, status leaves in transmit images.
// - Images move each cycle tick with fixed mapped object layout.
// - Mailbox reads and writes any object by request and response.
// - Profile position, velocity, torque, homing and cyclic modes are supported.
// - Fieldbus control acts only while the control mode equals nine.
`timescale 1ns/1ps
module fss_slave (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 state_req_valid_i,
  input  wire fss_pkg::fss_state_e  state_req_i,
  output fss_pkg::fss_state_e       state_o,
  output logic                      req_refused_o,
  input  wire logic                 mbx_req_valid_i,
  output logic                      mbx_req_ready_o,
  input  wire logic                 mbx_req_write_i,
  input  wire logic [15:0]          mbx_req_index_i,
  input  wire logic [7:0]           mbx_req_sub_i,
  input  wire logic [31:0]          mbx_req_data_i,
  output logic                      mbx_rsp_valid_o,
  input  wire logic                 mbx_rsp_ready_i,
  output logic [31:0]               mbx_rsp_data_o,
  output logic                      mbx_rsp_abort_o,
  input  wire logic                 cycle_tick_i,
  input  wire logic                 rx_pdo_valid_i,
  input  wire logic [63:0]          rx_pdo_data_i,
  output logic                      tx_pdo_valid_o,
  output logic [63:0]               tx_pdo_data_o,
  input  wire logic [15:0]          status_word_i,
  input  wire logic [31:0]          pos_actual_i,
  input  wire logic [15:0]          error_code_i,
  output logic                      bus_ctrl_o,
  output logic                      mode_ok_o,
  output logic [7:0]                op_mode_o,
  output logic [15:0]               cmd_ctrl_word_o,
  output logic [31:0]               cmd_target_pos_o,
  output logic [15:0]               cmd_probe_fn_o
);
  import fss_pkg::*;

  logic              rst_s1_r, rst_n_r;
  fss_state_e        state_r;
  logic              refused_r, rx_seen_r;
  logic              rsp_valid_r, rsp_abort_r;
  logic [31:0]       rsp_data_r;
  logic              tx_valid_r;
  logic [PDO_W-1:0]  tx_data_r;
  logic [1:0]        cur_lvl, req_lvl;
  logic              req_onehot, step_ok, mbx_open, mbx_take, od_hit, pdo_apply;
  logic [SLOT_W-1:0] od_slot;
  logic [31:0]       od_rdata;
  logic [7:0]        ctrl_mode;

  // Reset is released through two flops so all state leaves reset on the same edge.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  assign cur_lvl    = fss_level(state_r);
  assign req_lvl    = fss_level(state_req_i);
  assign req_onehot = state_req_i inside {FSS_INIT, FSS_PREOP, FSS_SAFEOP, FSS_OP};
  // Stepping to Operational also needs valid outputs seen, so the drive never runs on stale data.
  assign step_ok    = (req_lvl == cur_lvl + 2'd1) &&
                      (state_req_i != FSS_OP || rx_seen_r);

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r   <= FSS_INIT;
      refused_r <= 1'b0;
    end else begin
      refused_r <= 1'b0;
      if (state_req_valid_i) begin
        case (state_r)
          FSS_INIT, FSS_PREOP, FSS_SAFEOP, FSS_OP: begin
            if (!req_onehot) begin
              refused_r <= 1'b1;
            end else if (req_lvl <= cur_lvl) begin
              state_r <= state_req_i;
            end else if (step_ok) begin
              state_r <= state_req_i;
            end else begin
              refused_r <= 1'b1;
            end
          end
          default: state_r <= FSS_INIT;
        endcase
      end
    end
  end

  // Outputs received in Safe-Operational mark the link fit for Operational.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_seen_r <= 1'b0;
    end else if (state_r != FSS_SAFEOP) begin
      rx_seen_r <= 1'b0;
    end else if (rx_pdo_valid_i) begin
      rx_seen_r <= 1'b1;
    end
  end

  // Mailbox: one request in flight; the answer stands until the master takes it.
  assign mbx_open        = state_r != FSS_INIT;
  assign mbx_req_ready_o = mbx_open && !rsp_valid_r;
  assign mbx_take        = mbx_req_valid_i && mbx_req_ready_o;

  always_comb begin
    od_hit  = 1'b1;
    od_slot = SLOT_CTRL_MODE;
    case (mbx_req_index_i)
      OD_IDX_CTRL_MODE:  begin
        od_slot = SLOT_CTRL_MODE;
        od_hit  = mbx_req_sub_i == OD_SUB_CTRL_MODE;
      end
      OD_IDX_CTRL_WORD:  od_slot = SLOT_CTRL_WORD;
      OD_IDX_MODE_OP:    od_slot = SLOT_MODE_OP;
      OD_IDX_TARGET_POS: od_slot = SLOT_TARGET_POS;
      OD_IDX_PROBE_FN:   od_slot = SLOT_PROBE_FN;
      OD_IDX_ERR_CODE:   od_slot = SLOT_ERR_CODE;
      OD_IDX_STATUS:     od_slot = SLOT_STATUS;
      OD_IDX_POS_ACT:    od_slot = SLOT_POS_ACT;
      default:           od_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rsp_valid_r <= 1'b0;
      rsp_abort_r <= 1'b0;
      rsp_data_r  <= 32'h0000_0000;
    end else if (mbx_take) begin
      rsp_valid_r <= 1'b1;
      rsp_abort_r <= !od_hit;
      rsp_data_r  <= (mbx_req_write_i || !od_hit) ? 32'h0000_0000 : od_rdata;
    end else if (mbx_rsp_ready_i) begin
      rsp_valid_r <= 1'b0;
    end
  end

  // Received commands reach the drive only in Operational under fieldbus control.
  assign bus_ctrl_o = ctrl_mode == CTRL_MODE_BUS;
  assign pdo_apply  = rx_pdo_valid_i && state_r == FSS_OP && bus_ctrl_o;

  fss_od_store fss_od_store_inst (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_r),
    .sdo_wr_i         (mbx_take && mbx_req_write_i && od_hit),
    .sdo_slot_i       (od_slot),
    .sdo_wdata_i      (mbx_req_data_i),
    .pdo_wr_i         (pdo_apply),
    .pdo_ctrl_word_i  (rx_pdo_data_i[RX_CW_LSB +: 16]),
    .pdo_target_pos_i (rx_pdo_data_i[RX_POS_LSB +: 32]),
    .pdo_probe_fn_i   (rx_pdo_data_i[RX_PF_LSB +: 16]),
    .rd_data_o        (od_rdata),
    .ctrl_mode_o      (ctrl_mode),
    .mode_op_o        (op_mode_o),
    .ctrl_word_o      (cmd_ctrl_word_o),
    .target_pos_o     (cmd_target_pos_o),
    .probe_fn_o       (cmd_probe_fn_o)
  );

  assign mode_ok_o = op_mode_o inside {MODE_PP, MODE_PV, MODE_PT, MODE_HM,
                                       MODE_CSP, MODE_CSV, MODE_CST};

  // Transmit image is produced on each cycle tick once process data runs.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= '0;
    end else begin
      tx_valid_r <= cycle_tick_i && (state_r == FSS_SAFEOP || state_r == FSS_OP);
      if (cycle_tick_i) begin
        tx_data_r <= {error_code_i, pos_actual_i, status_word_i};
      end
    end
  end

  assign state_o         = state_r;
  assign req_refused_o   = refused_r;
  assign mbx_rsp_valid_o = rsp_valid_r;
  assign mbx_rsp_abort_o = rsp_abort_r;
  assign mbx_rsp_data_o  = rsp_data_r;
  assign tx_pdo_valid_o  = tx_valid_r;
  assign tx_pdo_data_o   = tx_data_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_r);

  state_onehot_a: assert property ($onehot(state_r))
    else $error("state is not one of the four");
  step_up_a: assert property (fss_level(state_r) > $past(fss_level(state_r)) |->
      fss_level(state_r) == $past(fss_level(state_r)) + 2'd1)
    else $error("upward move skipped a state");
  drop_down_a: assert property (state_req_valid_i && req_onehot && req_lvl < cur_lvl |=>
      state_r == $past(state_req_i))
    else $error("downward request not taken");
  init_silent_a: assert property (state_r == FSS_INIT |->
      !mbx_req_ready_o && !pdo_apply ##1 !tx_pdo_valid_o)
    else $error("traffic while in Init");
  // Levels are widened by a bit so that Operational plus one does not wrap round to Init.
  skip_refuse_a: assert property (state_req_valid_i && req_onehot &&
      {1'b0, req_lvl} > {1'b0, cur_lvl} + 3'd1 |=> req_refused_o && $stable(state_r))
    else $error("skipping request not refused");
  op_needs_rx_a: assert property (state_r == FSS_OP && $past(state_r) == FSS_SAFEOP |->
      $past(rx_seen_r))
    else $error("Operational entered without outputs");
  hold_outputs_a: assert property (state_r != FSS_OP && !mbx_take |=>
      $stable(cmd_target_pos_o) && $stable(cmd_ctrl_word_o))
    else $error("outputs applied outside Operational");
  mbx_answer_a: assert property (mbx_take |=> mbx_rsp_valid_o [*1] ##0
      (mbx_rsp_abort_o == !$past(od_hit)))
    else $error("mailbox answer missing or wrong");
  rsp_hold_a: assert property (mbx_rsp_valid_o && !mbx_rsp_ready_i |=>
      mbx_rsp_valid_o && $stable(mbx_rsp_data_o))
    else $error("mailbox answer dropped");
  tx_tick_a: assert property (cycle_tick_i && state_r == FSS_OP |=>
      tx_pdo_valid_o && tx_pdo_data_o[TX_POS_LSB +: 32] == $past(pos_actual_i))
    else $error("transmit image missing");
  bus_gate_a: assert property (rx_pdo_valid_i && state_r == FSS_OP && !bus_ctrl_o |=>
      $stable(cmd_ctrl_word_o) || $past(mbx_take))
    else $error("command applied outside fieldbus control");

  reach_op_c:  cover property (state_r == FSS_SAFEOP ##1 state_r == FSS_OP);
  op_to_init_c: cover property (state_r == FSS_OP ##1 state_r == FSS_INIT);
  refuse_c:    cover property (req_refused_o);
  mbx_abort_c: cover property (mbx_rsp_valid_o && mbx_rsp_abort_o);

endmodule // fss_slave

// *** fss_master_model.sv ***
// Behavioural fieldbus master: cyclic ticks and mailbox answer pickup.
`timescale 1ns/1ps
module fss_master_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [2:0] delay_i,
  input  wire logic       rsp_valid_i,
  output logic            rsp_ready_o,
  output logic            tick_o
);
  logic [2:0] tick_cnt_r;
  logic [2:0] wait_r;

  // The tick period is fixed so that image exchange stays strictly cyclic.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= 3'h0;
      tick_o     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 3'h1;
      tick_o     <= (tick_cnt_r == 3'h7);
    end
  end

  // A slow master lets the answer stand for delay_i plus one cycles before raising ready to take it.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_r      <= 3'h0;
      rsp_ready_o <= 1'b0;
    end else if (rsp_ready_o && rsp_valid_i) begin
      wait_r      <= 3'h0;
      rsp_ready_o <= 1'b0;
    end else if (rsp_valid_i) begin
      if (wait_r >= delay_i) begin
        rsp_ready_o <= 1'b1;
      end else begin
        wait_r <= wait_r + 3'h1;
      end
    end
  end
endmodule // fss_master_model

// *** fss_slave_tb.sv ***
// Self-checking testbench for the fieldbus slave state machine.
`timescale 1ns/1ps
module fss_slave_tb;
  import fss_pkg::*;
  logic        clk_i = 1'b0, rst_b_i = 1'b0, state_req_valid_i = 1'b0, mbx_req_valid_i = 1'b0;
  logic        mbx_req_write_i = 1'b0, rx_pdo_valid_i = 1'b0, mbx_rsp_ready_i, cycle_tick_i;
  logic        req_refused_o, mbx_req_ready_o, mbx_rsp_valid_o, mbx_rsp_abort_o;
  logic        tx_pdo_valid_o, bus_ctrl_o, mode_ok_o, st_seen = 1'b0;
  fss_state_e  state_req_i = FSS_INIT;
  fss_state_e  state_o;
  fss_state_e  st_d = FSS_INIT;
  logic [15:0] mbx_req_index_i = 16'h0, status_word_i = 16'h1234, error_code_i = 16'h0;
  logic [15:0] cmd_ctrl_word_o, cmd_probe_fn_o;
  logic [7:0]  mbx_req_sub_i = 8'h0, op_mode_o;
  logic [31:0] mbx_req_data_i = 32'h0, pos_actual_i = 32'h0, mbx_rsp_data_o, cmd_target_pos_o;
  logic [31:0] lfsr = 32'h0000_000f;
  logic [63:0] rx_pdo_data_i = 64'h0, tx_pdo_data_o, exp_cmd = 64'h0;
  logic [2:0]  delay = 3'h0;
  logic [4:0]  st_q[$];
  logic [32:0] mbx_q[$];
  logic [7:0]  modes [7] = '{MODE_PP, MODE_PV, MODE_PT, MODE_HM, MODE_CSP, MODE_CSV, MODE_CST};
  int          err_count = 0, compares = 0, tx_cnt = 0, snap;

  always #2.5 clk_i = ~clk_i;

  fss_slave fss_slave_inst (.clk_i, .rst_b_i, .state_req_valid_i, .state_req_i, .state_o,
    .req_refused_o, .mbx_req_valid_i, .mbx_req_ready_o, .mbx_req_write_i, .mbx_req_index_i,
    .mbx_req_sub_i, .mbx_req_data_i, .mbx_rsp_valid_o, .mbx_rsp_ready_i, .mbx_rsp_data_o,
    .mbx_rsp_abort_o, .cycle_tick_i, .rx_pdo_valid_i, .rx_pdo_data_i, .tx_pdo_valid_o,
    .tx_pdo_data_o, .status_word_i, .pos_actual_i, .error_code_i, .bus_ctrl_o, .mode_ok_o,
    .op_mode_o, .cmd_ctrl_word_o, .cmd_target_pos_o, .cmd_probe_fn_o);

  fss_master_model fss_master_model_inst (.clk_i, .rst_b_i, .delay_i(delay),
    .rsp_valid_i(mbx_rsp_valid_o), .rsp_ready_o(mbx_rsp_ready_i), .tick_o(cycle_tick_i));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_state(input fss_state_e got, input fss_state_e exp);
    chk_val({60'h0, got}, {60'h0, exp});
  endtask

  task automatic give_verdict;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic req(input fss_state_e t, input fss_state_e exp, input logic refused);
    st_q.push_back({refused, exp});
    @(posedge clk_i);
    state_req_valid_i <= 1'b1;
    state_req_i       <= t;
    @(posedge clk_i);
    state_req_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic mbx(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] d, input logic [31:0] exp, input logic ab);
    int n;
    n = 0;
    mbx_q.push_back({ab, exp});
    @(posedge clk_i);
    mbx_req_valid_i <= 1'b1;
    mbx_req_write_i <= wr;
    mbx_req_index_i <= idx;
    mbx_req_sub_i   <= sub;
    mbx_req_data_i  <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (mbx_req_ready_o !== 1'b1 && n < 50);
    mbx_req_valid_i <= 1'b0;
    mbx_req_data_i  <= ~d;
    while (mbx_q.size() != 0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk_val(mbx_q.size(), 64'h0);
  endtask

  // Only applied images move the expected command set; others must leave it alone.
  task automatic send_rx(input logic apply);
    logic [63:0] d;
    lfsr = lfsr_next(lfsr);
    d    = {lfsr, lfsr_next(lfsr)};
    lfsr = lfsr_next(lfsr);
    if (apply) exp_cmd = d;
    @(posedge clk_i);
    rx_pdo_valid_i <= 1'b1;
    rx_pdo_data_i  <= d;
    @(posedge clk_i);
    rx_pdo_valid_i <= 1'b0;
    rx_pdo_data_i  <= ~d;
    @(posedge clk_i);
    chk_val({cmd_probe_fn_o, cmd_target_pos_o, cmd_ctrl_word_o}, exp_cmd);
  endtask

  always @(posedge clk_i) begin
    if (st_seen) begin
      chk_state(state_o, fss_state_e'(st_q[0][3:0]));
      chk_val(req_refused_o, st_q[0][4]);
      void'(st_q.pop_front());
    end
    st_seen <= state_req_valid_i;
    if (mbx_rsp_valid_o && mbx_rsp_ready_i) begin
      chk_val({mbx_rsp_abort_o, mbx_rsp_data_o}, mbx_q.pop_front());
    end
    if (tx_pdo_valid_o) begin
      tx_cnt++;
      chk_val(st_d inside {FSS_SAFEOP, FSS_OP}, 1'b1);
      chk_val(tx_pdo_data_o, {error_code_i, pos_actual_i, status_word_i});
      status_word_i <= status_word_i + 16'h0101;
      pos_actual_i  <= pos_actual_i + 32'h0001_0003;
      error_code_i  <= error_code_i + 16'h0011;
    end
    st_d = state_o;
  end

  initial begin
    repeat (4000) @(posedge clk_i);
    err_count++;
    give_verdict;
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk_state(state_o, FSS_INIT);
    chk_val({mbx_req_ready_o, bus_ctrl_o}, 2'b01);
    req(FSS_SAFEOP, FSS_INIT, 1'b1);
    req(fss_state_e'(4'h3), FSS_INIT, 1'b1);
    req(FSS_OP, FSS_INIT, 1'b1);
    done("init");
    // Address, mailbox and clock are taken as set up before this request.
    req(FSS_PREOP, FSS_PREOP, 1'b0);
    foreach (modes[i]) begin
      mbx(1'b1, OD_IDX_MODE_OP, 8'h0, {24'h0, modes[i]}, 32'h0, 1'b0);
      chk_val({mode_ok_o, op_mode_o}, {1'b1, modes[i]});
    end
    mbx(1'b1, OD_IDX_MODE_OP, 8'h0, 32'h2, 32'h0, 1'b0);
    chk_val(mode_ok_o, 1'b0);
    mbx(1'b0, OD_IDX_MODE_OP, 8'h5, 32'h0, 32'h2, 1'b0);
    mbx(1'b0, 16'h1234, 8'h0, 32'h0, 32'h0, 1'b1);
    mbx(1'b1, OD_IDX_CTRL_MODE, 8'h2, 32'h5, 32'h0, 1'b1);
    chk_val(bus_ctrl_o, 1'b1);
    req(FSS_OP, FSS_PREOP, 1'b1);
    repeat (20) @(posedge clk_i);
    chk_val(tx_cnt == 0, 1'b1);
    done("preop");
    // Sync channels and mappings are taken as set up before this request.
    req(FSS_SAFEOP, FSS_SAFEOP, 1'b0);
    delay <= 3'h3;
    req(FSS_OP, FSS_SAFEOP, 1'b1);
    send_rx(1'b0);
    mbx(1'b0, OD_IDX_CTRL_WORD, 8'h0, 32'h0, 32'h0, 1'b0);
    chk_val(tx_cnt > 0, 1'b1);
    req(FSS_OP, FSS_OP, 1'b0);
    send_rx(1'b1);
    mbx(1'b0, OD_IDX_CTRL_WORD, 8'h0, 32'h0, {16'h0, exp_cmd[15:0]}, 1'b0);
    mbx(1'b1, OD_IDX_CTRL_MODE, 8'h1, 32'h5, 32'h0, 1'b0);
    chk_val(bus_ctrl_o, 1'b0);
    send_rx(1'b0);
    mbx(1'b1, OD_IDX_CTRL_MODE, 8'h1, 32'h9, 32'h0, 1'b0);
    send_rx(1'b1);
    done("op");
    req(FSS_INIT, FSS_INIT, 1'b0);
    chk_val(mbx_req_ready_o, 1'b0);
    snap = tx_cnt;
    repeat (20) @(posedge clk_i);
    chk_val(tx_cnt == snap, 1'b1);
    done("return");
    give_verdict;
  end
endmodule // fss_slave_tb
